/* logic/ebac_aux_ctrl.sv */
// ebac_aux_ctrl: address latch strobe, strobe stretching, expanded ram sizing and
// internal/external routing of data moves, behind one avalon-mm register port.
// assumes the core holds a transfer request until done and that the security byte is stable.
// Functional notes
// - with suppress clear, the latch strobe runs at 1/6 of the clock, 1/3 in double speed.
// - with suppress set, the latch strobe only appears for external moves, reads and fetches.
// - while the latch strobe is suppressed its pin is released and weakly pulled high.
// - read and write strobes last 6 clock periods, or 30 with stretch set.
// - the size field picks 256, 512, 768 (default), 1024 or 1792 bytes of internal ram.
// - with external select clear data moves below the selected size go to internal ram, the rest and all moves with it set go to the bus.
// - after power-up the external select bit is loaded from the security byte.
// - reset clears stretch and suppress, sets size to 010 and takes select from security.
//
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/1ps
module ebac_aux_ctrl (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rstn,
  // avalon-mm register port
  input wire logic [ebac_pkg::AVS_AW-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // security configuration
  input wire logic [7:0] i_security_config_byte,
  // transfer request from the core
  input wire logic i_xfer_req,
  input wire logic [1:0] i_xfer_kind,
  input wire logic i_xfer_wr,
  input wire logic [ebac_pkg::XADDR_W-1:0] i_xfer_addr,
  input wire logic [7:0] i_xfer_wdata,
  output logic o_xfer_done,
  output logic [7:0] o_xfer_rdata,
  // expanded internal ram
  output logic o_expanded_internal_ram_req,
  output logic o_expanded_internal_ram_wr,
  output logic [ebac_pkg::XADDR_W-1:0] o_expanded_internal_ram_addr,
  output logic [7:0] o_expanded_internal_ram_wdata,
  input wire logic [7:0] i_expanded_internal_ram_rdata,
  // external multiplexed bus pins
  output logic o_ale,
  output logic o_ale_oe,
  output logic o_ale_weak_pu,
  output logic o_rd_n,
  output logic o_wr_n,
  output logic [7:0] o_p0_out,
  output logic o_p0_oe,
  input wire logic [7:0] i_p0_in,
  output logic [7:0] o_p2_out
);
  import ebac_pkg::*;

  logic strobe_suppress;
  logic strobe_stretch;
  logic [2:0] expanded_internal_ram_size_sel;
  logic external_mem_select;
  logic x2_mode;
  logic sec_loaded;
  logic avs_ack;
  logic avs_wr_go;
  ebac_state_t state;
  logic [XADDR_W-1:0] addr_q;
  logic wr_q;
  logic [7:0] wdata_q;
  logic [4:0] len_q;
  logic [4:0] strb_cnt;
  logic last_internal;
  logic [2:0] ale_cnt;
  logic ale_tick;
  logic [2:0] ale_div;
  logic [7:0] p0_s1;
  logic [7:0] p0_s2;
  logic ext_active;
  logic take_internal;
  logic [7:0] aux_rd;
  logic [4:0] strb_low_cnt;

  // register bus: one wait cycle, then the access completes
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~avs_ack;
  assign avs_wr_go = i_avs_write & avs_ack;
  // reserved bits read as zero
  assign aux_rd = {2'b00, strobe_stretch, expanded_internal_ram_size_sel, external_mem_select, strobe_suppress};

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      avs_ack <= 1'b0;
    end else begin
      avs_ack <= (i_avs_read | i_avs_write) & ~avs_ack;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_avs_readdata <= 32'h0000_0000;
    end else if (i_avs_read && !avs_ack) begin
      case (i_avs_address)
        ADR_AUX: o_avs_readdata <= {24'h00_0000, aux_rd};
        ADR_MODE: o_avs_readdata <= {31'h0000_0000, x2_mode};
        ADR_STAT: o_avs_readdata <= {29'h0000_0000, last_internal, strobe_suppress,
                                     state != ST_IDLE};
        default: o_avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // control register; top two bits are never stored
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      strobe_suppress <= 1'b0;
      strobe_stretch <= 1'b0;
      expanded_internal_ram_size_sel <= XRS_RESET;
      external_mem_select <= 1'b0;
      sec_loaded <= 1'b0;
      x2_mode <= 1'b0;
    end else if (!sec_loaded) begin
      // strap caught on the first edge after release, not by the reset itself
      external_mem_select <= i_security_config_byte[SEC_EXTM_BIT];
      sec_loaded <= 1'b1;
    end else if (avs_wr_go && i_avs_address == ADR_AUX) begin
      strobe_suppress <= i_avs_writedata[B_SUPPRESS];
      strobe_stretch <= i_avs_writedata[B_STRETCH];
      expanded_internal_ram_size_sel <= i_avs_writedata[B_XRS_HI:B_XRS_LO];
      external_mem_select <= i_avs_writedata[B_EXTMEM];
    end else if (avs_wr_go && i_avs_address == ADR_MODE) begin
      x2_mode <= i_avs_writedata[B_X2];
    end
  end

  // latch strobe divider
  assign ale_div = x2_mode ? ALE_DIV_X2 : ALE_DIV_STD;
  assign ale_tick = (ale_cnt == 3'h0);

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      ale_cnt <= 3'h0;
    end else if (ale_cnt >= ale_div - 3'h1) begin
      ale_cnt <= 3'h0;
    end else begin
      ale_cnt <= ale_cnt + 3'h1;
    end
  end

  // port 0 read data comes from a pin: two flops before use
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      p0_s1 <= 8'h00;
      p0_s2 <= 8'h00;
    end else begin
      p0_s1 <= i_p0_in;
      p0_s2 <= p0_s1;
    end
  end

  // only indirect data moves below the selected size stay inside
  assign take_internal = (i_xfer_kind == KIND_MOVX) && !external_mem_select &&
                         (i_xfer_addr < ebac_expanded_internal_ram_size(expanded_internal_ram_size_sel));
  assign ext_active = (state == ST_ADDR) || (state == ST_STRB);
  assign o_xfer_done = (state == ST_DONE);

  // transfer sequencer; settings are latched at take so a later write waits its turn
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= ST_IDLE;
      addr_q <= 16'h0000;
      wr_q <= 1'b0;
      wdata_q <= 8'h00;
      len_q <= STRB_SHORT;
      strb_cnt <= 5'h00;
      last_internal <= 1'b0;
      o_xfer_rdata <= 8'h00;
      o_expanded_internal_ram_req <= 1'b0;
    end else begin
      o_expanded_internal_ram_req <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (i_xfer_req && sec_loaded) begin
            addr_q <= i_xfer_addr;
            wr_q <= i_xfer_wr && (i_xfer_kind == KIND_MOVX);
            wdata_q <= i_xfer_wdata;
            len_q <= strobe_stretch ? STRB_LONG : STRB_SHORT;
            last_internal <= take_internal;
            if (take_internal) begin
              o_expanded_internal_ram_req <= 1'b1;
              state <= ST_INT;
            end else begin
              state <= ST_ADDR;
            end
          end
        end
        ST_INT: state <= ST_IRD;
        ST_IRD: begin
          if (!wr_q) begin
            o_xfer_rdata <= i_expanded_internal_ram_rdata;
          end
          state <= ST_DONE;
        end
        ST_ADDR: begin
          strb_cnt <= len_q - 5'h01;
          state <= ST_STRB;
        end
        ST_STRB: begin
          if (strb_cnt == 5'h00) begin
            if (!wr_q) begin
              o_xfer_rdata <= p0_s2;
            end
            state <= ST_DONE;
          end else begin
            strb_cnt <= strb_cnt - 5'h01;
          end
        end
        ST_DONE: state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_expanded_internal_ram_wr <= 1'b0;
      o_expanded_internal_ram_addr <= 16'h0000;
      o_expanded_internal_ram_wdata <= 8'h00;
    end else if (i_xfer_req && state == ST_IDLE && take_internal) begin
      o_expanded_internal_ram_wr <= i_xfer_wr;
      o_expanded_internal_ram_addr <= i_xfer_addr;
      o_expanded_internal_ram_wdata <= i_xfer_wdata;
    end
  end

  // pins follow the sequencer one cycle later
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_ale <= 1'b0;
      o_ale_oe <= 1'b1;
      o_ale_weak_pu <= 1'b0;
    end else begin
      o_ale <= (state == ST_ADDR) || (!strobe_suppress && !ext_active && ale_tick);
      // released pin idles high through the weak pull, avoiding edges
      o_ale_oe <= !strobe_suppress || ext_active;
      o_ale_weak_pu <= strobe_suppress && !ext_active;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rd_n <= 1'b1;
      o_wr_n <= 1'b1;
      o_p0_out <= 8'h00;
      o_p0_oe <= 1'b0;
      o_p2_out <= 8'h00;
    end else begin
      o_rd_n <= !(state == ST_STRB && !wr_q);
      o_wr_n <= !(state == ST_STRB && wr_q);
      o_p0_out <= (state == ST_ADDR) ? addr_q[7:0] : wdata_q;
      o_p0_oe <= (state == ST_ADDR) || (state == ST_STRB && wr_q);
      o_p2_out <= ext_active ? addr_q[15:8] : o_p2_out;
    end
  end

  // helper: length of the last strobe pulse
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      strb_low_cnt <= 5'h00;
    end else if (!o_rd_n || !o_wr_n) begin
      strb_low_cnt <= strb_low_cnt + 5'h01;
    end else begin
      strb_low_cnt <= 5'h00;
    end
  end

  AST_ALE_DIV: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (ale_tick && !x2_mode) |=> (!ale_tick || x2_mode)[*5] ##1 (ale_tick || x2_mode))
    else $error("latch divider is not six cycles");
  AST_ALE_EMIT: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (!strobe_suppress && state == ST_IDLE && ale_tick) |=> (o_ale && o_ale_oe))
    else $error("latch pulse missing while not suppressed");
  AST_ALE_QUIET: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (strobe_suppress && state == ST_IDLE) |=> !o_ale)
    else $error("latch pulse emitted while suppressed");
  AST_ALE_WEAK: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (strobe_suppress && !ext_active) |=> (!o_ale_oe && o_ale_weak_pu))
    else $error("suppressed latch pin still driven");
  AST_STRB_LEN: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    ($rose(o_rd_n && o_wr_n) && sec_loaded) |-> (strb_low_cnt == len_q))
    else $error("strobe length wrong");
  AST_EXPANDED_INTERNAL_RAM_SIZE: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (state == ST_IDLE && i_xfer_req && sec_loaded && i_xfer_kind == KIND_MOVX &&
     !external_mem_select && i_xfer_addr < ebac_expanded_internal_ram_size(expanded_internal_ram_size_sel))
    |=> (state == ST_INT && o_expanded_internal_ram_req))
    else $error("in-range move not sent to internal ram");
  AST_EXT_ROUTE: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (state == ST_IDLE && i_xfer_req && sec_loaded && external_mem_select)
    |=> (state == ST_ADDR) ##1 (o_ale && !o_expanded_internal_ram_req))
    else $error("move with external select not sent to bus");
  AST_SEC_LOAD: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    $rose(sec_loaded) |-> (external_mem_select == $past(i_security_config_byte[SEC_EXTM_BIT])))
    else $error("external select not taken from security byte");
  AST_RESET_VAL: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    $rose(sec_loaded) |-> (!strobe_suppress && !strobe_stretch && expanded_internal_ram_size_sel == XRS_RESET))
    else $error("control register reset value wrong");
  AST_WRITE_NEXT: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (avs_wr_go && sec_loaded && i_avs_address == ADR_AUX) |=>
    (strobe_stretch == $past(i_avs_writedata[B_STRETCH]) &&
     expanded_internal_ram_size_sel == $past(i_avs_writedata[B_XRS_HI:B_XRS_LO])))
    else $error("control write not applied on the next cycle");
endmodule

/* logic/ebac_pkg.sv */
// ebac_pkg: constants, register map and types for the external bus auxiliary control.
// assumes a 32-bit avalon-mm register port with byte addresses and one 125 MHz clock.
package ebac_pkg;
  localparam int unsigned AVS_AW = 10;
  localparam int unsigned XADDR_W = 16;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_AUX = 8'h8e;
  localparam logic [7:0] IDX_MODE = 8'h8f;
  localparam logic [7:0] IDX_STAT = 8'h90;
  localparam logic [AVS_AW-1:0] ADR_AUX = {IDX_AUX, 2'b00};
  localparam logic [AVS_AW-1:0] ADR_MODE = {IDX_MODE, 2'b00};
  localparam logic [AVS_AW-1:0] ADR_STAT = {IDX_STAT, 2'b00};
  // aux_bus_control fields
  localparam int unsigned B_SUPPRESS = 0;
  localparam int unsigned B_EXTMEM = 1;
  localparam int unsigned B_XRS_LO = 2;
  localparam int unsigned B_XRS_HI = 4;
  localparam int unsigned B_STRETCH = 5;
  localparam logic [2:0] XRS_RESET = 3'h2;
  // mode register: bit 0 double-speed; status register fields
  localparam int unsigned B_X2 = 0;
  localparam int unsigned B_ST_BUSY = 0;
  localparam int unsigned B_ST_ALE_OFF = 1;
  localparam int unsigned B_ST_LAST_INT = 2;
  // bit of the security byte that carries the external memory choice
  localparam int unsigned SEC_EXTM_BIT = 0;
  // address latch divider, in oscillator periods
  localparam logic [2:0] ALE_DIV_STD = 3'h6;
  localparam logic [2:0] ALE_DIV_X2 = 3'h3;
  // read/write strobe widths in clock periods
  localparam logic [4:0] STRB_SHORT = 5'h06;
  localparam logic [4:0] STRB_LONG = 5'h1e;
  // expanded internal ram sizes in bytes
  localparam logic [XADDR_W-1:0] XSZ_256 = 16'h0100;
  localparam logic [XADDR_W-1:0] XSZ_512 = 16'h0200;
  localparam logic [XADDR_W-1:0] XSZ_768 = 16'h0300;
  localparam logic [XADDR_W-1:0] XSZ_1024 = 16'h0400;
  localparam logic [XADDR_W-1:0] XSZ_1792 = 16'h0700;
  // transfer kinds from the core
  localparam logic [1:0] KIND_MOVX = 2'h0;
  localparam logic [1:0] KIND_CODE_READ = 2'h1;
  localparam logic [1:0] KIND_FETCH = 2'h2;
  typedef enum logic [2:0] {ST_IDLE, ST_INT, ST_IRD, ST_ADDR, ST_STRB, ST_DONE} ebac_state_t;

  function automatic logic [XADDR_W-1:0] ebac_expanded_internal_ram_size(input logic [2:0] sel);
    case (sel)
      3'h0: ebac_expanded_internal_ram_size = XSZ_256;
      3'h1: ebac_expanded_internal_ram_size = XSZ_512;
      3'h2: ebac_expanded_internal_ram_size = XSZ_768;
      3'h3: ebac_expanded_internal_ram_size = XSZ_1024;
      default: ebac_expanded_internal_ram_size = XSZ_1792;
    endcase
  endfunction
endpackage

/* testbench/ebac_ext_mem.sv */
// ebac_ext_mem: external memory on the multiplexed bus, 256 bytes mirrored over the space.
// assumes the address is latched on ale from port 0 and that the strobes are active low.
`timescale 1ns/1ps
module ebac_ext_mem (
  // clock
  input wire logic i_mclk,
  // bus pins as the memory sees them
  input wire logic i_ale,
  input wire logic i_rd_n,
  input wire logic i_wr_n,
  input wire logic [7:0] i_p0_out,
  input wire logic i_p0_oe,
  output logic [7:0] o_p0_in
);
  logic [7:0] mem [256];
  logic [7:0] lat = 8'h00;
  logic [7:0] last = 8'h00;
  initial begin
    for (int k = 0; k < 256; k++) mem[k] = 8'(k) ^ 8'h5a;
  end
  // port 0 has no pull-up: a released bus toggles so stale data never passes for a read
  always_comb begin
    if (i_p0_oe) o_p0_in = i_p0_out;
    else if (!i_rd_n) o_p0_in = mem[lat];
    else o_p0_in = ~last;
  end
  always @(posedge i_mclk) begin
    last <= o_p0_in;
    if (i_ale && i_p0_oe) lat <= i_p0_out;
    if (!i_wr_n && i_p0_oe) mem[lat] <= i_p0_out;
  end
endmodule

/* testbench/testbench.sv */
// testbench: drives the register port and the core transfer port, answers internal ram.
// assumes ebac_pkg constants; the external memory model sits on the pins.
`timescale 1ns/1ps
module testbench;
  import ebac_pkg::*;
  logic mclk, rstn, avs_rd, avs_wr, avs_wait, xreq, xwr, done, expanded_internal_ram_req, expanded_internal_ram_wr;
  logic ale, ale_oe, ale_pu, rd_n, wr_n, p0_oe;
  logic [AVS_AW-1:0] avs_addr;
  logic [31:0] avs_wdata, avs_rdata, rq;
  logic [7:0] sec, xwdata, xrdata, x_rd, expanded_internal_ram_rdata, expanded_internal_ram_wdata, p0_out, p0_in, p2_out;
  logic [1:0] xkind;
  logic [XADDR_W-1:0] xaddr, expanded_internal_ram_addr;
  logic [15:0] sizes [5] = '{16'h0100, 16'h0200, 16'h0300, 16'h0400, 16'h0700};
  int errors = 0;
  int cmp_count = 0;
  int x_cyc, x_low, x_int, x_ale;

  ebac_aux_ctrl u_dut (
    .i_mclk(mclk), .i_rstn(rstn), .i_avs_address(avs_addr), .i_avs_read(avs_rd),
    .i_avs_write(avs_wr), .i_avs_writedata(avs_wdata), .o_avs_readdata(avs_rdata),
    .o_avs_waitrequest(avs_wait), .i_security_config_byte(sec), .i_xfer_req(xreq),
    .i_xfer_kind(xkind), .i_xfer_wr(xwr), .i_xfer_addr(xaddr), .i_xfer_wdata(xwdata),
    .o_xfer_done(done), .o_xfer_rdata(xrdata), .o_expanded_internal_ram_req(expanded_internal_ram_req), .o_expanded_internal_ram_wr(expanded_internal_ram_wr),
    .o_expanded_internal_ram_addr(expanded_internal_ram_addr), .o_expanded_internal_ram_wdata(expanded_internal_ram_wdata), .i_expanded_internal_ram_rdata(expanded_internal_ram_rdata),
    .o_ale(ale), .o_ale_oe(ale_oe), .o_ale_weak_pu(ale_pu), .o_rd_n(rd_n), .o_wr_n(wr_n),
    .o_p0_out(p0_out), .o_p0_oe(p0_oe), .i_p0_in(p0_in), .o_p2_out(p2_out)
  );
  ebac_ext_mem u_mem (
    .i_mclk(mclk), .i_ale(ale), .i_rd_n(rd_n), .i_wr_n(wr_n), .i_p0_out(p0_out),
    .i_p0_oe(p0_oe), .o_p0_in(p0_in)
  );

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // internal ram answers in the cycle after its request
  always @(posedge mclk) begin
    if (expanded_internal_ram_req === 1'b1) expanded_internal_ram_rdata <= expanded_internal_ram_addr[7:0] ^ 8'hc3;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    if (errors == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic tmo();
    errors++;
    finish_test();
  endtask
  task automatic do_reset(input logic [7:0] s);
    rstn <= 1'b0;
    sec <= s;
    repeat (10) @(posedge mclk);
    rstn <= 1'b1;
    repeat (2) @(posedge mclk);
  endtask
  // request held until waitrequest is sampled low at a rising edge, released at that edge
  task automatic bus(input logic w, input logic [AVS_AW-1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_addr <= a;
    avs_wdata <= (a == ADR_AUX) ? (d & 32'h3f) : d;
    avs_wr <= w;
    avs_rd <= ~w;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_wait !== 1'b0 && n < 50);
    if (n >= 50) tmo();
    rq = avs_rdata;
    avs_wr <= 1'b0;
    avs_rd <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic xfer(input logic [1:0] k, input logic w, input logic [15:0] a,
                      input logic [7:0] d);
    {x_cyc, x_low, x_int, x_ale} = '0;
    xkind <= k;
    xwr <= w;
    xaddr <= a;
    xwdata <= d;
    xreq <= 1'b1;
    do begin
      @(posedge mclk);
      x_cyc++;
      if (rd_n === 1'b0 || wr_n === 1'b0) x_low++;
      if (expanded_internal_ram_req === 1'b1) x_int++;
      if (ale === 1'b1) x_ale++;
    end while (done !== 1'b1 && x_cyc < 100);
    if (x_cyc >= 100) tmo();
    x_rd = xrdata;
    xreq <= 1'b0;
    @(posedge mclk);
  endtask
  // len 0 means the move stayed inside; external done shares the last strobe cycle
  task automatic path(input int len);
    check(x_cyc, (len == 0) ? 4 : 3 + len);
    check(x_low, len);
    check(x_int, (len == 0) ? 1 : 0);
  endtask
  task automatic ale_gap(input int exp);
    int n;
    for (n = 0; n < 20; n++) begin
      @(negedge mclk);
      if (ale === 1'b1) break;
    end
    for (n = 1; n < 20; n++) begin
      @(negedge mclk);
      if (ale === 1'b1) break;
    end
    check(n, exp);
    check({ale_oe, ale_pu}, 2'b10);
    @(posedge mclk);
  endtask

  task automatic t_regs();
    bus(1'b0, ADR_AUX, 32'h0);
    check(rq, 32'h08);
    bus(1'b0, ADR_MODE, 32'h0);
    check(rq, 32'h0);
    bus(1'b1, ADR_AUX, 32'h3f);
    bus(1'b0, 10'h000, 32'h0);
    check(rq, 32'h0);
    bus(1'b0, ADR_AUX, 32'h0);
    check(rq, 32'h3f);
    bus(1'b1, ADR_AUX, 32'h08);
  endtask
  task automatic t_ale_rate();
    ale_gap(6);
    bus(1'b1, ADR_MODE, 32'h1 << B_X2);
    repeat (8) @(posedge mclk);
    ale_gap(3);
    bus(1'b1, ADR_MODE, 32'h0);
  endtask
  // every kind of external access still pulses the latch strobe once
  task automatic t_suppress();
    bus(1'b1, ADR_AUX, 32'h09);
    repeat (2) @(posedge mclk);
    repeat (20) begin
      @(negedge mclk);
      check({ale, ale_oe, ale_pu}, 3'b001);
    end
    @(posedge mclk);
    for (int k = 0; k < 3; k++) begin
      xfer(2'(k), 1'b0, 16'h0480, 8'h00);
      check(x_ale, 1);
    end
    bus(1'b1, ADR_AUX, 32'h08);
  endtask
  task automatic t_strobe();
    bus(1'b1, ADR_AUX, 32'h0a);
    xfer(KIND_MOVX, 1'b1, 16'h1210, 8'ha5);
    path(6);
    check(p2_out, 8'h12);
    xfer(KIND_MOVX, 1'b0, 16'h1210, 8'h00);
    check(x_rd, 8'ha5);
    bus(1'b1, ADR_AUX, 32'h2a);
    xfer(KIND_MOVX, 1'b0, 16'h0033, 8'h00);
    path(30);
    check(x_rd, 8'h33 ^ 8'h5a);
  endtask
  // one below the size stays inside, the size itself goes out
  task automatic t_size();
    for (int c = 0; c < 5; c++) begin
      bus(1'b1, ADR_AUX, 32'(c) << B_XRS_LO);
      xfer(KIND_MOVX, 1'b0, sizes[c] - 16'h1, 8'h00);
      path(0);
      check(x_rd, 8'hff ^ 8'hc3);
      xfer(KIND_MOVX, 1'b0, sizes[c], 8'h00);
      path(6);
      check(x_rd, 8'h5a);
    end
    xfer(KIND_MOVX, 1'b1, 16'h0012, 8'h77);
    path(0);
    check({expanded_internal_ram_wr, expanded_internal_ram_addr, expanded_internal_ram_wdata}, {1'b1, 16'h0012, 8'h77});
    bus(1'b0, ADR_STAT, 32'h0);
    check(rq, 32'h4);
  endtask
  task automatic t_security();
    do_reset(8'h01);
    bus(1'b0, ADR_AUX, 32'h0);
    check(rq, 32'h0a);
    xfer(KIND_MOVX, 1'b0, 16'h0005, 8'h00);
    path(6);
    check(x_rd, 8'h05 ^ 8'h5a);
  endtask

  initial begin
    rstn = 1'b0;
    sec = 8'h00;
    {avs_rd, avs_wr, xreq, xwr, avs_addr, avs_wdata, xkind, xaddr, xwdata, expanded_internal_ram_rdata} = '0;
    do_reset(8'h00);
    t_regs();
    t_ale_rate();
    t_suppress();
    t_strobe();
    t_size();
    t_security();
    finish_test();
  end
endmodule
